// ### hdl/tsg_pkg.sv
// package for the transmitter wave-shaping gear adaptation block
// assumes one clock domain; all users reference items as tsg_pkg::name
package tsg_pkg;

    // ------------------------------------------------------------
    // table geometry
    // ------------------------------------------------------------
    localparam int TSG_ENTRIES     = 16;
    localparam int TSG_ENTRY_W     = 32;
    localparam int TSG_GEAR_W      = 4;
    localparam int TSG_PROTO_CNT   = 13;
    localparam int TSG_PROTO_IDX_W = 4;

    // ------------------------------------------------------------
    // entry field positions
    // ------------------------------------------------------------
    localparam int TSG_GEAR_LSB    = 0;
    localparam int TSG_FALL_LSB    = 4;
    localparam int TSG_RISE_LSB    = 8;
    localparam int TSG_RESID_LSB   = 12;
    localparam int TSG_MASK_LSB    = 16;
    localparam int TSG_RSVD_LSB    = 29;
    localparam int TSG_DELTA_W     = 4;

    // ------------------------------------------------------------
    // field widths, limits and codes
    // ------------------------------------------------------------
    localparam int TSG_TAU_W       = 4;
    localparam int TSG_RESID_W     = 5;
    localparam int TSG_MODE_W      = 3;
    localparam logic [3:0] TSG_TAU_MIN   = 4'h0;
    localparam logic [3:0] TSG_TAU_MAX   = 4'hF;
    localparam logic [4:0] TSG_RESID_MIN = 5'h1F;
    localparam logic [3:0] TSG_GEAR_MIN  = 4'h1;
    localparam logic [3:0] TSG_GEAR_MAX  = 4'hE;
    localparam logic [2:0] TSG_MODE_PUSH_PULL = 3'h7;
    localparam logic [2:0] TSG_MODE_FULL_AM   = 3'h1;
    localparam logic [2:0] TSG_MODE_TEN_PCT   = 3'h7;
    localparam logic [2:0] TSG_MODE_IDLE      = 3'h0;

    // protocol index of the first type B bit rate in the mask
    localparam logic [3:0] TSG_PROTO_B_FIRST  = 4'h4;
    localparam logic [3:0] TSG_PROTO_B_LAST   = 4'h7;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] fall_time_const;
        logic [3:0] rise_time_const;
        logic [4:0] resid_carrier;
    } tsg_shape_s;

    typedef struct packed {
        logic       overshoot_guard_en;
        logic       cap_shaping_skip;
        logic       undershoot_guard_en;
        logic [3:0] undershoot_pattern_length;
        logic [2:0] transition_drive_mode;
        logic [2:0] modulation_drive_mode;
    } tsg_mode_s;

    localparam tsg_shape_s TSG_SHAPE_RST = '{4'h0, 4'h0, 5'h1F};
    localparam tsg_mode_s  TSG_MODE_RST  = '{1'b0, 1'b0, 1'b0, 4'h0, 3'h0, 3'h0};

endpackage

// ### hdl/tsg_tx_shaping_gear_adapt.sv
// transmitter wave-shaping control with per-gear delta adaptation
// assumes protocol load, gear and table writes come from logic on clk_sys_in
// Functional notes
// - cap shaping active only when skip bit zero
// - rise time constant is 4-bit, 0 to F
// - residual carrier applies at pulse end always
// - push-pull transition mode applies residual at start
// - residual carrier is type B depth level
// - modulation mode 001 type A, 111 type B
// - transition mode ignored while undershoot guard off
// - protocol load installs gear 0 base values
// - higher gears add deltas of entries up to gear
// - lower gear restores its accumulated value
// - table holds 16 entries of 32 bits
// - entry with gear below previous is ignored
// - bits 28..16 form the protocol mask
// - entry applies only when protocol bit set
// - three sign-magnitude deltas, range -7..+7
// - entry gear valid from 1 to 14
// - residual zero full depth, 1F none
`timescale 1ns/100ps

module tsg_tx_shaping_gear_adapt #(
    parameter int N_ENTRIES = tsg_pkg::TSG_ENTRIES,     // table depth
    parameter int ENTRY_W   = tsg_pkg::TSG_ENTRY_W      // entry width
) (
    input  wire logic                   clk_sys_in,     // 40 MHz system clock
    input  wire logic                   rstn_in,        // async reset, active low
    input  wire logic                   ce_in,          // clock enable, freezes all
    input  wire logic                   proto_load_in,  // pulse: load protocol base
    input  wire logic [3:0]             proto_sel_in,   // active protocol index 0..12
    input  wire tsg_pkg::tsg_shape_s    base_shape_in,  // protocol base shaping values
    input  wire tsg_pkg::tsg_mode_s     base_mode_in,   // protocol base drive modes
    input  wire logic [3:0]             gear_in,        // current power gear
    input  wire logic                   tbl_wr_in,      // table entry write strobe
    input  wire logic [3:0]             tbl_addr_in,    // table entry index
    input  wire logic [ENTRY_W-1:0]     tbl_data_in,    // table entry word
    input  wire logic [4:0]             tbl_count_in,   // number of valid entries
    output logic [3:0]                  fall_time_const_out,   // effective fall constant
    output logic [3:0]                  rise_time_const_out,   // effective rise constant
    output logic [4:0]                  resid_end_out,         // residual at pulse end
    output logic [4:0]                  resid_start_out,       // residual at pulse start
    output logic                        resid_start_en_out,    // start residual in use
    output logic [4:0]                  typeb_depth_out,       // type B modulation depth
    output logic                        cap_shaping_on_out,    // switched-cap shaping on
    output logic                        overshoot_guard_en_out,  // overshoot guard enable
    output logic                        undershoot_guard_en_out, // undershoot guard enable
    output logic [3:0]                  undershoot_pattern_length_out, // pattern length
    output logic [2:0]                  transition_drive_mode_out,     // effective mode
    output logic [2:0]                  modulation_drive_mode_out,     // modulation mode
    output logic                        mode_mismatch_out,     // modulation mode unusual
    output logic [3:0]                  gear_out               // gear values belong to
);

    // ------------------------------------------------------------
    // adaptation table storage
    // ------------------------------------------------------------
    logic [ENTRY_W-1:0] table_mem [N_ENTRIES];
    logic [4:0]         entry_count;

    // table is loaded from configuration memory one word at a time
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            for (int i = 0; i < N_ENTRIES; i++) begin
                table_mem[i] <= '0;
            end
            entry_count <= 5'h00;
        end else if (ce_in) begin
            if (tbl_wr_in) begin
                table_mem[tbl_addr_in] <= tbl_data_in;
            end
            if (tbl_count_in > 5'(N_ENTRIES)) begin
                entry_count <= 5'(N_ENTRIES);
            end else begin
                entry_count <= tbl_count_in;
            end
        end
    end

    // ------------------------------------------------------------
    // protocol base, held as the gear 0 values
    // ------------------------------------------------------------
    tsg_pkg::tsg_shape_s base_shape;
    tsg_pkg::tsg_mode_s  base_mode;
    logic [3:0]          proto_sel;

    // base captured on protocol load only
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            base_shape <= tsg_pkg::TSG_SHAPE_RST;
            base_mode  <= tsg_pkg::TSG_MODE_RST;
            proto_sel  <= 4'h0;
        end else if (ce_in && proto_load_in) begin
            base_shape <= base_shape_in;
            base_mode  <= base_mode_in;
            proto_sel  <= proto_sel_in;
        end
    end

    // ------------------------------------------------------------
    // per-entry qualification and signed deltas
    // ------------------------------------------------------------
    logic        entry_hit  [N_ENTRIES];
    logic [3:0]  entry_gear [N_ENTRIES];
    logic signed [5:0] d_fall  [N_ENTRIES];
    logic signed [5:0] d_rise  [N_ENTRIES];
    logic signed [5:0] d_resid [N_ENTRIES];

    // sign-magnitude to two's complement, magnitude 0..7
    function automatic logic signed [5:0] sm_to_int(input logic [3:0] sm);
        logic signed [5:0] mag;
        mag = $signed({3'b000, sm[2:0]});
        return sm[3] ? -mag : mag;
    endfunction

    for (genvar g = 0; g < N_ENTRIES; g++) begin : gen_entry
        logic [ENTRY_W-1:0] w;
        logic               proto_ok;
        logic               order_ok;
        assign w = table_mem[g];
        assign entry_gear[g] = w[tsg_pkg::TSG_GEAR_LSB +: tsg_pkg::TSG_GEAR_W];
        // mask bit of the active protocol, 13 bits above the deltas
        assign proto_ok = (proto_sel < 4'(tsg_pkg::TSG_PROTO_CNT)) &&
                          w[tsg_pkg::TSG_MASK_LSB + proto_sel];
        // an entry whose gear drops below its predecessor is skipped
        if (g == 0) begin : gen_first
            assign order_ok = 1'b1;
        end else begin : gen_rest
            assign order_ok = entry_gear[g] >=
                table_mem[g-1][tsg_pkg::TSG_GEAR_LSB +: tsg_pkg::TSG_GEAR_W];
        end
        assign entry_hit[g] = (5'(g) < entry_count) && proto_ok && order_ok &&
                              (entry_gear[g] >= tsg_pkg::TSG_GEAR_MIN) &&
                              (entry_gear[g] <= tsg_pkg::TSG_GEAR_MAX) &&
                              (entry_gear[g] <= gear_in);
        assign d_fall[g]  = sm_to_int(w[tsg_pkg::TSG_FALL_LSB  +: tsg_pkg::TSG_DELTA_W]);
        assign d_rise[g]  = sm_to_int(w[tsg_pkg::TSG_RISE_LSB  +: tsg_pkg::TSG_DELTA_W]);
        assign d_resid[g] = sm_to_int(w[tsg_pkg::TSG_RESID_LSB +: tsg_pkg::TSG_DELTA_W]);
    end

    // ------------------------------------------------------------
    // accumulation from the base, recomputed from scratch each cycle
    // ------------------------------------------------------------
    // summing from base every cycle makes a gear drop exact, no undo needed
    logic signed [9:0] sum_fall;
    logic signed [9:0] sum_rise;
    logic signed [9:0] sum_resid;
    tsg_pkg::tsg_shape_s next_shape;

    always_comb begin
        sum_fall  = $signed({6'b000000, base_shape.fall_time_const});
        sum_rise  = $signed({6'b000000, base_shape.rise_time_const});
        sum_resid = $signed({5'b00000, base_shape.resid_carrier});
        for (int i = 0; i < N_ENTRIES; i++) begin
            if (entry_hit[i]) begin
                sum_fall  = sum_fall  + 10'(d_fall[i]);
                sum_rise  = sum_rise  + 10'(d_rise[i]);
                sum_resid = sum_resid + 10'(d_resid[i]);
            end
        end
        next_shape = base_shape;
        if (gear_in != 4'h0) begin
            // clamp rather than wrap
            next_shape.fall_time_const = (sum_fall < 0) ? tsg_pkg::TSG_TAU_MIN :
                (sum_fall > 10'sd15) ? tsg_pkg::TSG_TAU_MAX : sum_fall[3:0];
            next_shape.rise_time_const = (sum_rise < 0) ? tsg_pkg::TSG_TAU_MIN :
                (sum_rise > 10'sd15) ? tsg_pkg::TSG_TAU_MAX : sum_rise[3:0];
            next_shape.resid_carrier = (sum_resid < 0) ? 5'h00 :
                (sum_resid > 10'sd31) ? tsg_pkg::TSG_RESID_MIN : sum_resid[4:0];
        end
    end

    // ------------------------------------------------------------
    // effective shaping outputs, registered one cycle after change
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            fall_time_const_out <= tsg_pkg::TSG_TAU_MIN;
            rise_time_const_out <= tsg_pkg::TSG_TAU_MIN;
            resid_end_out       <= tsg_pkg::TSG_RESID_MIN;
            typeb_depth_out     <= tsg_pkg::TSG_RESID_MIN;
            gear_out            <= 4'h0;
        end else if (ce_in) begin
            fall_time_const_out <= next_shape.fall_time_const;
            rise_time_const_out <= next_shape.rise_time_const;
            resid_end_out       <= next_shape.resid_carrier;
            typeb_depth_out     <= next_shape.resid_carrier;
            gear_out            <= gear_in;
        end
    end

    // ------------------------------------------------------------
    // drive modes and guard enables
    // ------------------------------------------------------------
    logic       proto_is_b;
    logic [2:0] next_trans_mode;
    assign proto_is_b = (proto_sel >= tsg_pkg::TSG_PROTO_B_FIRST) &&
                        (proto_sel <= tsg_pkg::TSG_PROTO_B_LAST);
    // transition mode has no effect while undershoot guard is off
    assign next_trans_mode = base_mode.undershoot_guard_en ?
                             base_mode.transition_drive_mode : tsg_pkg::TSG_MODE_IDLE;

    // start residual value always follows; its enable is set only when transitions are push-pull
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            resid_start_out    <= tsg_pkg::TSG_RESID_MIN;
            resid_start_en_out <= 1'b0;
        end else if (ce_in) begin
            resid_start_en_out <= base_mode.undershoot_guard_en &&
                                  (next_trans_mode == tsg_pkg::TSG_MODE_PUSH_PULL);
            resid_start_out    <= next_shape.resid_carrier;
        end
    end

    // guard and shaping controls follow the protocol base directly
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cap_shaping_on_out            <= 1'b0;
            overshoot_guard_en_out        <= 1'b0;
            undershoot_guard_en_out       <= 1'b0;
            undershoot_pattern_length_out <= 4'h0;
            transition_drive_mode_out     <= tsg_pkg::TSG_MODE_IDLE;
            modulation_drive_mode_out     <= tsg_pkg::TSG_MODE_IDLE;
            mode_mismatch_out             <= 1'b0;
        end else if (ce_in) begin
            cap_shaping_on_out            <= ~base_mode.cap_shaping_skip;
            // passed through; software is expected to keep it low
            overshoot_guard_en_out        <= base_mode.overshoot_guard_en;
            undershoot_guard_en_out       <= base_mode.undershoot_guard_en;
            undershoot_pattern_length_out <= base_mode.undershoot_pattern_length;
            transition_drive_mode_out     <= next_trans_mode;
            modulation_drive_mode_out     <= base_mode.modulation_drive_mode;
            // flag a type B protocol not using 111, or type A not using 001
            mode_mismatch_out <= proto_is_b ?
                (base_mode.modulation_drive_mode != tsg_pkg::TSG_MODE_TEN_PCT) :
                ((proto_sel < tsg_pkg::TSG_PROTO_B_FIRST) &&
                 (base_mode.modulation_drive_mode != tsg_pkg::TSG_MODE_FULL_AM));
        end
    end

endmodule

// ### tb/tsg_chk.sv
// assertion checker for the wave-shaping gear adaptation block
// assumes it is bound to the block top and sees only its ports
`timescale 1ns/100ps
module tsg_chk (
    input wire logic                clk_sys_in,                  // clock
    input wire logic                rstn_in,                     // reset, active low
    input wire logic                ce_in,                       // clock enable
    input wire logic                proto_load_in,               // protocol load
    input wire tsg_pkg::tsg_shape_s base_shape_in,               // base shaping
    input wire tsg_pkg::tsg_mode_s  base_mode_in,                // base modes
    input wire logic [3:0]          gear_in,                     // gear
    input wire logic [3:0]          fall_time_const_out,         // fall constant
    input wire logic [3:0]          rise_time_const_out,         // rise constant
    input wire logic [4:0]          resid_end_out,               // end residual
    input wire logic [4:0]          resid_start_out,             // start residual
    input wire logic                resid_start_en_out,          // start residual on
    input wire logic [4:0]          typeb_depth_out,             // type B depth
    input wire logic                cap_shaping_on_out,          // cap shaping on
    input wire logic                undershoot_guard_en_out,     // undershoot guard
    input wire logic [2:0]          transition_drive_mode_out,   // transition mode
    input wire logic [2:0]          modulation_drive_mode_out,   // modulation mode
    input wire logic [3:0]          gear_out                     // gear seen
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);

    // a protocol load followed by a quiet cycle at gear 0
    sequence s_load;
        (proto_load_in && ce_in) ##1 (ce_in && !proto_load_in && gear_in == 4'h0);
    endsequence

    base_shape_a: assert property (s_load |=>
        {fall_time_const_out, rise_time_const_out, resid_end_out} == $past(base_shape_in, 2))
        else $error("gear 0 values differ from loaded base");
    cap_shape_a: assert property (s_load |=>
        cap_shaping_on_out == !$past(base_mode_in.cap_shaping_skip, 2))
        else $error("cap shaping state wrong");
    mod_mode_a: assert property (s_load |=>
        modulation_drive_mode_out == $past(base_mode_in.modulation_drive_mode, 2))
        else $error("modulation mode wrong");
    trans_idle_a: assert property (s_load |=> transition_drive_mode_out ==
        ($past(base_mode_in.undershoot_guard_en, 2) ?
         $past(base_mode_in.transition_drive_mode, 2) : 3'h0))
        else $error("transition mode not idled");
    start_resid_a: assert property (resid_start_en_out ==
        (undershoot_guard_en_out && transition_drive_mode_out == 3'h7))
        else $error("start residual enable wrong");
    end_start_a: assert property (resid_start_out == resid_end_out)
        else $error("start and end residual differ");
    depth_same_a: assert property (typeb_depth_out == resid_end_out)
        else $error("type B depth differs from residual");
    gear_track_a: assert property (ce_in |=> gear_out == $past(gear_in))
        else $error("gear not applied next cycle");
endmodule

bind tsg_tx_shaping_gear_adapt tsg_chk u_chk (
    .clk_sys_in, .rstn_in, .ce_in, .proto_load_in, .base_shape_in, .base_mode_in,
    .gear_in, .fall_time_const_out, .rise_time_const_out, .resid_end_out,
    .resid_start_out, .resid_start_en_out, .typeb_depth_out, .cap_shaping_on_out,
    .undershoot_guard_en_out, .transition_drive_mode_out, .modulation_drive_mode_out,
    .gear_out
);

// ### tb/tsg_cfg_model.sv
// configuration memory model that streams the adaptation table
// assumes the block samples the table pins on the rising clock edge
`timescale 1ns/100ps
module tsg_cfg_model (
    input  wire logic clk_sys_in,        // system clock
    output logic        tbl_wr_out,    // entry write strobe
    output logic [3:0]  tbl_addr_out,  // entry index
    output logic [31:0] tbl_data_out,  // entry word
    output logic [4:0]  tbl_count_out  // valid entry count
);
    // idle state; count stays 0 until a table is loaded
    initial begin
        tbl_wr_out    = 1'b0;
        tbl_addr_out  = 4'h0;
        tbl_data_out  = 32'h0;
        tbl_count_out = 5'h0;
    end

    // whole table, 16 words of 32 bits, count last so no half table counts
    task automatic load(input logic [31:0] ent [16], input logic [4:0] n);
        for (int i = 0; i < 16; i++) begin
            @(posedge clk_sys_in);
            tbl_wr_out   <= 1'b1;
            tbl_addr_out <= i[3:0];
            tbl_data_out <= ent[i];
        end
        @(posedge clk_sys_in);
        tbl_wr_out    <= 1'b0;
        tbl_data_out  <= ~tbl_data_out; // released bus never shows stale data
        tbl_count_out <= n;
        @(posedge clk_sys_in);
    endtask
endmodule

// ### tb/tsg_tx_shaping_gear_adapt_test.sv
// self-checking bench for the wave-shaping gear adaptation block
// assumes one 40 MHz clock; expected values worked by hand from the deltas
`timescale 1ns/100ps
module tsg_tx_shaping_gear_adapt_test;
    logic                clk_sys_in    = 1'b0;
    logic                rstn_in       = 1'b0;
    logic                ce_in         = 1'b1;
    logic                proto_load_in = 1'b0;
    logic [3:0]          proto_sel_in  = 4'h0;
    tsg_pkg::tsg_shape_s base_shape_in = tsg_pkg::TSG_SHAPE_RST;
    tsg_pkg::tsg_mode_s  base_mode_in  = tsg_pkg::TSG_MODE_RST;
    logic [3:0]          gear_in       = 4'h0;
    logic                tbl_wr;
    logic [3:0]          tbl_addr, fall, rise;
    logic [31:0]         tbl_data;
    logic [4:0]          tbl_count, resid;
    logic [2:0]          tdm, mdm;
    logic                cap_on, mm, rse, og, ug;
    logic [3:0]          upl, gq;
    int                  miscompares     = 0;
    int                  samples_checked = 0;

    always #12.5 clk_sys_in = ~clk_sys_in;

    tsg_cfg_model m_cfg (.clk_sys_in(clk_sys_in), .tbl_wr_out(tbl_wr), .tbl_addr_out(tbl_addr),
        .tbl_data_out(tbl_data), .tbl_count_out(tbl_count));

    tsg_tx_shaping_gear_adapt u_tsg_tx_shaping_gear_adapt (.clk_sys_in(clk_sys_in),
        .rstn_in(rstn_in), .ce_in(ce_in), .proto_load_in(proto_load_in),
        .proto_sel_in(proto_sel_in), .base_shape_in(base_shape_in),
        .base_mode_in(base_mode_in), .gear_in(gear_in), .tbl_wr_in(tbl_wr),
        .tbl_addr_in(tbl_addr), .tbl_data_in(tbl_data), .tbl_count_in(tbl_count),
        .fall_time_const_out(fall), .rise_time_const_out(rise), .resid_end_out(resid),
        .resid_start_out(), .resid_start_en_out(rse), .typeb_depth_out(),
        .cap_shaping_on_out(cap_on), .overshoot_guard_en_out(og), .undershoot_guard_en_out(ug),
        .undershoot_pattern_length_out(upl), .transition_drive_mode_out(tdm),
        .modulation_drive_mode_out(mdm), .mode_mismatch_out(mm), .gear_out(gq));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // five leading entries, rest zero; gears and order written as given, not checked
    task automatic put(input logic [31:0] a, b, c, d, e, input logic [4:0] n);
        logic [31:0] t [16];
        t = '{0: a, 1: b, 2: c, 3: d, 4: e, default: 32'h0};
        m_cfg.load(t, n);
    endtask

    // overshoot guard bit always left clear by this software
    task automatic load(input logic [12:0] s, input logic [12:0] m, input logic [3:0] p);
        @(posedge clk_sys_in);
        proto_load_in <= 1'b1;
        base_shape_in <= s;
        base_mode_in  <= m;
        proto_sel_in  <= p;
        @(posedge clk_sys_in);
        proto_load_in <= 1'b0;
        @(posedge clk_sys_in);
        #1;
    endtask

    // expected shape packed as fall, rise, residual
    task automatic at_gear(input logic [3:0] g, input logic [12:0] exp);
        @(posedge clk_sys_in);
        gear_in <= g;
        @(posedge clk_sys_in);
        #1;
        check(16'({fall, rise, resid}), 16'(exp));
    endtask

    // two-entry walk up and down the gears; third entry lies beyond the count
    task automatic t_walk;
        logic [3:0]  wg [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h2, 4'h0};
        logic [12:0] we [7] = '{13'h087E, 13'h0C3B, 13'h0C3B, 13'h0C1C, 13'h0C1C,
                                13'h0C3B, 13'h087E};
        put(32'h0001_BA21, 32'h0001_1983, 32'h0001_0704, 32'h0, 32'h0, 5'h02);
        load(13'h087E, 13'h001, 4'h0);
        for (int i = 0; i < 7; i++) begin
            at_gear(wg[i], we[i]);
        end
    endtask

    // each protocol bit enables its entry only; reserved bits set and ignored
    task automatic t_mask;
        for (int p = 0; p < 13; p++) begin
            put(32'hE000_0011 | (32'h1 << (16 + p)), 32'h0, 32'h0, 32'h0, 32'h0, 5'h01);
            load(13'h087E, 13'h001, p[3:0]);
            at_gear(4'h1, 13'h0A7E);
            load(13'h087E, 13'h001, 4'((p + 1) % 13));
            at_gear(4'h1, 13'h087E);
        end
    endtask

    // gear 0 entry, a descending entry and a gear 15 entry all refused
    task automatic t_order;
        put(32'h0001_0500, 32'h0001_0103, 32'h0001_0202, 32'h0001_0093, 32'h0001_007F, 5'h05);
        load(13'h087E, 13'h001, 4'h0);
        at_gear(4'h2, 13'h087E);
        at_gear(4'h3, 13'h069E);
        at_gear(4'hF, 13'h069E);
    endtask

    // sums clamp once at the end, not per gear step
    task automatic t_clamp;
        put(32'h0001_77F1, 32'h0001_FF02, 32'h0, 32'h0, 32'h0, 5'h02);
        load(13'h03DC, 13'h001, 4'h0);
        at_gear(4'h1, 13'h01FF);
        at_gear(4'h2, 13'h01DC);
        at_gear(4'h0, 13'h03DC);
    endtask

    // clock enable low: load pulse is lost, gear change held off until it rises
    task automatic t_freeze;
        @(posedge clk_sys_in);
        ce_in <= 1'b0;
        load(13'h087E, 13'h001, 4'h0);
        at_gear(4'h2, 13'h03DC);
        check(16'(gq), 16'h0000);
        @(posedge clk_sys_in);
        ce_in <= 1'b1;
        @(posedge clk_sys_in);
        #1;
        check(16'({fall, rise, resid}), 16'h01DC);
        check(16'(gq), 16'h0002);
        at_gear(4'h0, 13'h03DC);
    endtask

    // expected cap_on, transition, modulation, mismatch, start residual enable
    task automatic t_modes;
        logic [12:0] md [4] = '{13'h04F9, 13'h083F, 13'h07EF, 13'h0001};
        logic [3:0]  pr [4] = '{4'h0, 4'h0, 4'h4, 4'h4};
        logic [8:0]  ex [4] = '{9'h1E5, 9'h01E, 9'h1BC, 9'h106};
        logic [5:0]  eg [4] = '{6'h13, 6'h00, 6'h1F, 6'h00};
        for (int i = 0; i < 4; i++) begin
            load(13'h087E, md[i], pr[i]);
            check(16'({cap_on, tdm, mdm, mm, rse}), 16'(ex[i]));
            check(16'({og, ug, upl}), 16'(eg[i]));
        end
    endtask

    initial begin
        repeat (20) @(posedge clk_sys_in);
        rstn_in <= 1'b1;
        @(posedge clk_sys_in);
        #1;
        check(16'({fall, rise, resid}), 16'h001F);
        t_walk();
        t_mask();
        t_order();
        t_clamp();
        t_freeze();
        t_modes();
        give_verdict();
    end

    // hang guard; running out counts as a mismatch
    initial begin
        repeat (60000) @(posedge clk_sys_in);
        miscompares++;
        give_verdict();
    end
endmodule
